// ---- sdc_decoder.sv ----
`timescale 1ns/1ps
// Summary of operation
// - opcode zero changes nothing at all
// - opcode 1100 reads back wiper and buffer
// - opcode 0100 writes low byte to wiper
// - opcode 1010 reads back the addressed slot
// - opcode 0010 programs slot with nine bits
// - opcode 1011 loads slot into wiper, buffer
// - opcode 0011 stores wiper and buffer to slot
// - opcode 0111 raises wiper by one
// - opcode 1111 lowers wiper by one
// - up and down saturate, never wrap
// - opcode 1000 enters sleep
// - opcode 0001 leaves sleep
// - opcode 1101 erases the addressed slot
// - opcode 1001 is a software power-up reset
// - fields are opcode, slot, channel
// - serial output changes on falling clock
// - asleep after power-up, reset or sleep
// - asleep keeps wiper, ignores all but wake
// - buffer select changes only by slot load
// - each slot holds nine bits
// - write guard low blocks erase and program
// - power-up loads slot zero into wiper
module sdc_decoder (
    // system side
    input  wire logic       CLK,
    input  wire logic       RST_N,
    // serial link
    input  wire logic       SCLK,
    input  wire logic       CS_N,
    input  wire logic       SDI,
    output logic            SDO,
    // write guard pin
    input  wire logic       WP_N,
    // potentiometer state
    output logic [7:0]      WIPER,
    output logic            BUF_SEL,
    output logic            ASLEEP
);
    // ---------------- link clock domain ----------------
    logic [4:0]  bit_cnt;
    logic [23:0] shift;
    logic [23:0] word;
    logic        word_tgl;
    logic        rb_s1;
    logic        rb_s2;
    logic        rb_seen;
    logic [8:0]  rb_link;
    logic [8:0]  rb;
    logic        rb_tgl;
    logic        link_clr;
    wire  [23:0] out_word;
    wire         last_bit;

    // link clear too, as chip select may sit high from time zero
    // frame of 24 clocks
    always_ff @(posedge SCLK or posedge CS_N or posedge link_clr) begin
        if (CS_N || link_clr) begin
            bit_cnt <= sdc_pkg::BIT_NONE;
        end else begin
            bit_cnt <= last_bit ? sdc_pkg::BIT_NONE : 5'(bit_cnt + 5'h01);
        end
    end

    assign last_bit = (bit_cnt == sdc_pkg::BIT_LAST);

    always_ff @(posedge SCLK) begin
        shift <= {shift[22:0], SDI};
    end

    // word stays stable until the next full frame, so the
    // system side may read it after the toggle arrives
    always_ff @(posedge SCLK) begin
        if (last_bit) begin
            word <= {shift[22:0], SDI};
        end
    end

    always_ff @(posedge SCLK or posedge link_clr) begin
        if (link_clr) begin
            word_tgl <= 1'b0;
        end else if (last_bit) begin
            word_tgl <= ~word_tgl;
        end
    end

    // readback word crosses by toggle handshake
    always_ff @(posedge SCLK or posedge link_clr) begin
        if (link_clr) begin
            rb_s1   <= 1'b0;
            rb_s2   <= 1'b0;
            rb_seen <= 1'b0;
            rb_link <= sdc_pkg::RB_RESET;
        end else begin
            rb_s1   <= rb_tgl;
            rb_s2   <= rb_s1;
            rb_seen <= rb_s2;
            if (rb_s2 != rb_seen) begin
                rb_link <= rb;
            end
        end
    end

    assign out_word = {{(sdc_pkg::WORD_W - sdc_pkg::NV_W){1'b0}},
                       rb_link};

    always_ff @(negedge SCLK or posedge CS_N or posedge link_clr) begin
        if (CS_N || link_clr) begin
            SDO <= 1'b0;
        end else begin
            SDO <= out_word[5'(sdc_pkg::BIT_LAST - bit_cnt)];
        end
    end

    // ---------------- system clock domain ----------------
    sdc_pkg::sdc_pwr_t pwr;
    sdc_pkg::sdc_pwr_t next_pwr;
    logic        tgl_s1;
    logic        tgl_s2;
    logic        tgl_seen;
    logic        cs_s1;
    logic        cs_s2;
    logic        cs_d1;
    logic        cs_d2;
    logic        wp_s1;
    logic        wp_s2;
    logic [8:0]  nv [sdc_pkg::NV_DEPTH];
    logic [7:0]  next_wiper;
    logic        next_buf;
    logic [8:0]  next_rb;
    logic        nv_we;
    logic [8:0]  nv_din;

    always_ff @(posedge CLK) begin
        tgl_s1 <= word_tgl;
        tgl_s2 <= tgl_s1;
        cs_s1  <= CS_N;
        cs_s2  <= cs_s1;
        wp_s1  <= WP_N;
        wp_s2  <= wp_s1;
    end

    // chip select gets one extra stage so the word toggle,
    // which leads it on the pins, is always seen first
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cs_d1    <= 1'b1;
            cs_d2    <= 1'b1;
            link_clr <= 1'b1;
        end else begin
            cs_d1    <= cs_s2;
            cs_d2    <= cs_d1;
            link_clr <= 1'b0;
        end
    end

    wire [3:0] op      = word[sdc_pkg::OP_LSB +: 4];
    wire [1:0] slot    = word[sdc_pkg::SLOT_LSB +: 2];
    wire [1:0] chan    = word[sdc_pkg::CH_LSB +: 2];
    wire [7:0] d_tap   = word[sdc_pkg::TAP_W-1:0];
    wire [8:0] d_nv    = word[sdc_pkg::NV_W-1:0];
    wire       pending = (tgl_s2 != tgl_seen);
    wire       go      = pending && cs_d1 && !cs_d2;
    wire       awake   = (pwr == sdc_pkg::SDC_AWAKE);
    wire       ch_ok   = (chan == sdc_pkg::CH_OWN);
    wire       act     = go && awake;
    wire       act_ch  = act && ch_ok;
    wire [8:0] nv_q    = nv[slot];
    wire       nv_ok   = wp_s2;
    wire       at_max  = (WIPER == sdc_pkg::TAP_MAX);
    wire       at_min  = (WIPER == sdc_pkg::TAP_MIN);

    always_comb begin
        next_pwr   = pwr;
        next_wiper = WIPER;
        next_buf   = BUF_SEL;
        next_rb    = rb;
        nv_we      = 1'b0;
        nv_din     = nv_q;
        case (pwr)
            sdc_pkg::SDC_BOOT: begin
                next_wiper = nv[0][sdc_pkg::TAP_W-1:0];
                next_buf   = nv[0][sdc_pkg::BUF_BIT];
                next_pwr   = sdc_pkg::SDC_SLEEP;
            end
            sdc_pkg::SDC_SLEEP: begin
                if (go && op == sdc_pkg::OP_WAKE) begin
                    next_pwr = sdc_pkg::SDC_AWAKE;
                end
            end
            sdc_pkg::SDC_AWAKE: begin
                // zero opcode and others do nothing
                case (op)
                    sdc_pkg::OP_SLEEP: begin
                        if (go) next_pwr = sdc_pkg::SDC_SLEEP;
                    end
                    sdc_pkg::OP_POR: begin
                        if (go) next_pwr = sdc_pkg::SDC_BOOT;
                    end
                    sdc_pkg::OP_RD_TAP: begin
                        if (act_ch) next_rb = {BUF_SEL, WIPER};
                    end
                    sdc_pkg::OP_RD_NV: begin
                        if (act_ch) next_rb = nv_q;
                    end
                    sdc_pkg::OP_WR_TAP: begin
                        if (act_ch) next_wiper = d_tap;
                    end
                    sdc_pkg::OP_LOAD: begin
                        if (act_ch) begin
                            next_wiper = nv_q[sdc_pkg::TAP_W-1:0];
                            next_buf   = nv_q[sdc_pkg::BUF_BIT];
                        end
                    end
                    sdc_pkg::OP_UP: begin
                        if (act_ch && !at_max) begin
                            next_wiper = 8'(WIPER + sdc_pkg::TAP_STEP);
                        end
                    end
                    sdc_pkg::OP_DOWN: begin
                        if (act_ch && !at_min) begin
                            next_wiper = 8'(WIPER - sdc_pkg::TAP_STEP);
                        end
                    end
                    sdc_pkg::OP_PROG: begin
                        nv_we  = act_ch && nv_ok;
                        nv_din = d_nv;
                    end
                    sdc_pkg::OP_STORE: begin
                        nv_we  = act_ch && nv_ok;
                        nv_din = {BUF_SEL, WIPER};
                    end
                    sdc_pkg::OP_ERASE: begin
                        nv_we  = act_ch && nv_ok;
                        nv_din = sdc_pkg::NV_ERASED;
                    end
                    default: begin
                        next_pwr = pwr;
                    end
                endcase
            end
            default: begin
                next_pwr = sdc_pkg::SDC_SLEEP;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pwr      <= sdc_pkg::SDC_BOOT;
            ASLEEP   <= 1'b1;
            WIPER    <= sdc_pkg::TAP_MIN;
            BUF_SEL  <= 1'b0;
            rb       <= sdc_pkg::RB_RESET;
            rb_tgl   <= 1'b0;
            tgl_seen <= 1'b0;
        end else begin
            pwr      <= next_pwr;
            ASLEEP   <= (next_pwr != sdc_pkg::SDC_AWAKE);
            WIPER    <= next_wiper;
            BUF_SEL  <= next_buf;
            rb       <= next_rb;
            rb_tgl   <= rb_tgl ^ (next_rb != rb);
            tgl_seen <= go ? tgl_s2 : tgl_seen;
        end
    end

    for (genvar i = 0; i < sdc_pkg::NV_DEPTH; i++) begin : g_slot
        always_ff @(posedge CLK) begin
            if (!RST_N) begin
                nv[i] <= sdc_pkg::NV_ERASED;
            end else if (nv_we && slot == 2'(i)) begin
                nv[i] <= nv_din;
            end
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence s_cmd(logic [3:0] c);
        act_ch && op == c;
    endsequence

    sequence s_boot_done;
        pwr == sdc_pkg::SDC_BOOT ##1 ASLEEP;
    endsequence

    a_idle_cmd: assert property (
        go && op == sdc_pkg::OP_IDLE |=> $stable(WIPER) &&
        $stable(BUF_SEL) && $stable(ASLEEP) && $stable(rb))
        else $error("idle command changed state");

    a_write_tap: assert property (
        s_cmd(sdc_pkg::OP_WR_TAP) |=>
        WIPER == $past(d_tap) && $stable(BUF_SEL))
        else $error("direct write wrong");

    a_inc_step: assert property (
        s_cmd(sdc_pkg::OP_UP) ##0 !at_max |=>
        WIPER == 8'($past(WIPER) + sdc_pkg::TAP_STEP))
        else $error("up did not step by one");

    a_dec_floor: assert property (
        s_cmd(sdc_pkg::OP_DOWN) ##0 at_min |=>
        WIPER == sdc_pkg::TAP_MIN)
        else $error("down wrapped below zero");

    a_load_slot: assert property (
        s_cmd(sdc_pkg::OP_LOAD) |=>
        {BUF_SEL, WIPER} == $past(nv_q))
        else $error("slot load wrong");

    a_sleep_ignore: assert property (
        pwr == sdc_pkg::SDC_SLEEP && go && op != sdc_pkg::OP_WAKE
        |=> $stable(WIPER) && ASLEEP && $stable(nv_q))
        else $error("command acted while asleep");

    a_wake_up: assert property (
        pwr == sdc_pkg::SDC_SLEEP && go && op == sdc_pkg::OP_WAKE
        |=> !ASLEEP)
        else $error("wake did not leave sleep");

    a_guard_block: assert property (
        act && !nv_ok && (op == sdc_pkg::OP_PROG ||
        op == sdc_pkg::OP_ERASE || op == sdc_pkg::OP_STORE)
        |=> $stable(nv_q))
        else $error("guarded slot was written");

    a_soft_reset: assert property (
        act && op == sdc_pkg::OP_POR |=> s_boot_done ##0
        WIPER == nv[0][sdc_pkg::TAP_W-1:0])
        else $error("software reset did not reload");
endmodule

// ---- sdc_pkg.sv ----
package sdc_pkg;
    // command word layout, sent most significant bit first
    localparam int WORD_W   = 24;
    localparam int OP_LSB   = 20;
    localparam int SLOT_LSB = 18;
    localparam int CH_LSB   = 16;
    localparam int TAP_W    = 8;
    localparam int NV_W     = 9;
    localparam int BUF_BIT  = 8;
    localparam int NV_DEPTH = 4;

    localparam logic [4:0] BIT_LAST = 5'h17;
    localparam logic [4:0] BIT_NONE = 5'h00;

    // opcode_bits values
    localparam logic [3:0] OP_IDLE   = 4'h0;
    localparam logic [3:0] OP_WAKE   = 4'h1;
    localparam logic [3:0] OP_PROG   = 4'h2;
    localparam logic [3:0] OP_STORE  = 4'h3;
    localparam logic [3:0] OP_WR_TAP = 4'h4;
    localparam logic [3:0] OP_UP     = 4'h7;
    localparam logic [3:0] OP_SLEEP  = 4'h8;
    localparam logic [3:0] OP_POR    = 4'h9;
    localparam logic [3:0] OP_RD_NV  = 4'hA;
    localparam logic [3:0] OP_LOAD   = 4'hB;
    localparam logic [3:0] OP_RD_TAP = 4'hC;
    localparam logic [3:0] OP_ERASE  = 4'hD;
    localparam logic [3:0] OP_DOWN   = 4'hF;

    localparam logic [1:0] CH_OWN    = 2'h0;
    localparam logic [7:0] TAP_MAX   = 8'hFF;
    localparam logic [7:0] TAP_MIN   = 8'h00;
    localparam logic [7:0] TAP_STEP  = 8'h01;
    localparam logic [8:0] NV_ERASED = 9'h000;
    localparam logic [8:0] RB_RESET  = 9'h000;

    typedef enum logic [1:0] {
        SDC_BOOT,
        SDC_SLEEP,
        SDC_AWAKE
    } sdc_pwr_t;
endpackage

// ---- sdc_master.sv ----
`timescale 1ns/1ps
module sdc_master (
    // serial link
    output logic        sclk,
    output logic        cs_n,
    output logic        sdi,
    input  wire logic   sdo
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi  = 1'b1;
    end

    task automatic xfer(input logic [23:0] word, output logic [23:0] seen);
        seen = 24'h000000;
        // odd offset keeps the link out of step with the system clock
        #7;
        cs_n = 1'b0;
        #24;
        for (int i = 23; i >= 0; i--) begin
            sdi = word[i];
            #24;
            sclk = 1'b1;
            seen = {seen[22:0], sdo};
            #24;
            sclk = 1'b0;
        end
        // released data line shows the inverse, not a stale copy
        sdi = ~word[0];
        #100;
        cs_n = 1'b1;
        #1100;
    endtask
endmodule

// ---- sdc_decoder_tb.sv ----
`timescale 1ns/1ps
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin \
    n_fail++; $display("[ERR] %s expected %0h seen %0h", what, exp, got); \
    end end
module sdc_decoder_tb;
    localparam int LIMIT = 3000;
    logic        clk;
    logic        rst_n;
    logic        wp_n;
    logic        sclk;
    logic        cs_n;
    logic        sdi;
    logic        sdo;
    logic [7:0]  wiper;
    logic        buf_sel;
    logic        asleep;
    logic [23:0] rb;
    int          n_fail = 0;
    int          checked = 0;
    int          cycles = 0;

    sdc_decoder u_dut (
        .CLK(clk), .RST_N(rst_n), .SCLK(sclk), .CS_N(cs_n), .SDI(sdi),
        .SDO(sdo), .WP_N(wp_n), .WIPER(wiper), .BUF_SEL(buf_sel),
        .ASLEEP(asleep)
    );
    sdc_master u_mst (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic wrap_up();
        if (n_fail == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic cmd(input logic [3:0] op, input logic [1:0] slot,
                       input logic [1:0] ch, input logic [8:0] data);
        @(negedge clk);
        u_mst.xfer({op, slot, ch, 7'h00, data}, rb);
    endtask

    task automatic st(input logic [7:0] w, input logic b, input logic s);
        `CHK("wiper", w, wiper)
        `CHK("buffer", b, buf_sel)
        `CHK("asleep", s, asleep)
    endtask

    task automatic t_boot();
        st(8'h00, 1'b0, 1'b1);
        cmd(sdc_pkg::OP_WR_TAP, 2'h0, sdc_pkg::CH_OWN, 9'h0AB);
        st(8'h00, 1'b0, 1'b1);
        cmd(sdc_pkg::OP_WAKE, 2'h0, 2'h0, 9'h000);
        st(8'h00, 1'b0, 1'b0);
    endtask

    task automatic t_tap();
        logic [3:0] idle_ops [4] = '{4'h0, 4'h5, 4'h6, 4'hE};
        cmd(sdc_pkg::OP_WR_TAP, 2'h0, sdc_pkg::CH_OWN, 9'h0FE);
        st(8'hFE, 1'b0, 1'b0);
        cmd(sdc_pkg::OP_UP, 2'h0, sdc_pkg::CH_OWN, 9'h000);
        st(8'hFF, 1'b0, 1'b0);
        cmd(sdc_pkg::OP_UP, 2'h0, sdc_pkg::CH_OWN, 9'h000);
        st(8'hFF, 1'b0, 1'b0);
        cmd(sdc_pkg::OP_WR_TAP, 2'h3, sdc_pkg::CH_OWN, 9'h101);
        st(8'h01, 1'b0, 1'b0);
        cmd(sdc_pkg::OP_DOWN, 2'h0, sdc_pkg::CH_OWN, 9'h000);
        st(8'h00, 1'b0, 1'b0);
        cmd(sdc_pkg::OP_DOWN, 2'h0, sdc_pkg::CH_OWN, 9'h000);
        st(8'h00, 1'b0, 1'b0);
        cmd(sdc_pkg::OP_WR_TAP, 2'h0, 2'h1, 9'h044);
        st(8'h00, 1'b0, 1'b0);
        foreach (idle_ops[k]) begin
            cmd(idle_ops[k], 2'h0, sdc_pkg::CH_OWN, 9'h1FF);
            st(8'h00, 1'b0, 1'b0);
        end
    endtask

    task automatic t_nvm();
        cmd(sdc_pkg::OP_ERASE, 2'h2, sdc_pkg::CH_OWN, 9'h000);
        cmd(sdc_pkg::OP_PROG, 2'h2, sdc_pkg::CH_OWN, 9'h1C3);
        cmd(sdc_pkg::OP_LOAD, 2'h2, sdc_pkg::CH_OWN, 9'h000);
        st(8'hC3, 1'b1, 1'b0);
        cmd(sdc_pkg::OP_RD_NV, 2'h2, sdc_pkg::CH_OWN, 9'h000);
        cmd(sdc_pkg::OP_IDLE, 2'h0, 2'h0, 9'h000);
        `CHK("slot readback", 24'h0001C3, rb)
        `CHK("sdo idle", 1'b0, sdo)
        cmd(sdc_pkg::OP_WR_TAP, 2'h0, sdc_pkg::CH_OWN, 9'h055);
        cmd(sdc_pkg::OP_RD_TAP, 2'h0, sdc_pkg::CH_OWN, 9'h000);
        cmd(sdc_pkg::OP_IDLE, 2'h0, 2'h0, 9'h000);
        `CHK("tap readback", 24'h000155, rb)
        cmd(sdc_pkg::OP_ERASE, 2'h1, sdc_pkg::CH_OWN, 9'h000);
        cmd(sdc_pkg::OP_STORE, 2'h1, sdc_pkg::CH_OWN, 9'h000);
        cmd(sdc_pkg::OP_WR_TAP, 2'h0, sdc_pkg::CH_OWN, 9'h000);
        cmd(sdc_pkg::OP_LOAD, 2'h1, sdc_pkg::CH_OWN, 9'h000);
        st(8'h55, 1'b1, 1'b0);
        cmd(sdc_pkg::OP_ERASE, 2'h2, sdc_pkg::CH_OWN, 9'h000);
        cmd(sdc_pkg::OP_LOAD, 2'h2, sdc_pkg::CH_OWN, 9'h000);
        st(8'h00, 1'b0, 1'b0);
    endtask

    task automatic t_guard();
        @(posedge clk) wp_n <= 1'b0;
        cmd(sdc_pkg::OP_ERASE, 2'h1, sdc_pkg::CH_OWN, 9'h000);
        cmd(sdc_pkg::OP_PROG, 2'h1, sdc_pkg::CH_OWN, 9'h0AA);
        cmd(sdc_pkg::OP_WR_TAP, 2'h0, sdc_pkg::CH_OWN, 9'h033);
        cmd(sdc_pkg::OP_STORE, 2'h1, sdc_pkg::CH_OWN, 9'h000);
        st(8'h33, 1'b0, 1'b0);
        cmd(sdc_pkg::OP_LOAD, 2'h1, sdc_pkg::CH_OWN, 9'h000);
        st(8'h55, 1'b1, 1'b0);
        @(posedge clk) wp_n <= 1'b1;
    endtask

    task automatic t_power();
        cmd(sdc_pkg::OP_ERASE, 2'h0, sdc_pkg::CH_OWN, 9'h000);
        cmd(sdc_pkg::OP_PROG, 2'h0, sdc_pkg::CH_OWN, 9'h077);
        cmd(sdc_pkg::OP_WR_TAP, 2'h0, sdc_pkg::CH_OWN, 9'h010);
        cmd(sdc_pkg::OP_SLEEP, 2'h0, 2'h0, 9'h000);
        st(8'h10, 1'b1, 1'b1);
        cmd(sdc_pkg::OP_WR_TAP, 2'h0, sdc_pkg::CH_OWN, 9'h020);
        cmd(sdc_pkg::OP_UP, 2'h0, sdc_pkg::CH_OWN, 9'h000);
        st(8'h10, 1'b1, 1'b1);
        cmd(sdc_pkg::OP_WAKE, 2'h0, 2'h0, 9'h000);
        st(8'h10, 1'b1, 1'b0);
        cmd(sdc_pkg::OP_POR, 2'h0, 2'h0, 9'h000);
        st(8'h77, 1'b0, 1'b1);
    endtask

    initial begin
        rst_n = 1'b0;
        wp_n  = 1'b1;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_boot();
        t_tap();
        t_nvm();
        t_guard();
        t_power();
        wrap_up();
    end
endmodule
